// ==== core/ttp_pkg.sv ====
// constants and types shared by the triple timer pwm core
package ttp_pkg;

	// ----------------------------------------------------------------
	// bus and map
	// ----------------------------------------------------------------
	localparam int          TTP_AW         = 12;
	localparam int          TTP_DW         = 32;
	localparam int          TTP_NUM_TMR    = 3;
	localparam logic [11:0] TTP_GSC_OFS    = 12'h000;
	localparam logic [11:0] TTP_TMR_BASE   = 12'h020;
	localparam logic [11:0] TTP_TMR_STRIDE = 12'h020;
	localparam logic [4:0]  TTP_CFG_OFS    = 5'h00;
	localparam logic [4:0]  TTP_CNTH_OFS   = 5'h04;
	localparam logic [4:0]  TTP_CNTL_OFS   = 5'h08;
	localparam logic [4:0]  TTP_PRDH_OFS   = 5'h0c;
	localparam logic [4:0]  TTP_PRDL_OFS   = 5'h10;
	localparam logic [4:0]  TTP_WIDH_OFS   = 5'h14;
	localparam logic [4:0]  TTP_WIDL_OFS   = 5'h18;

	// ----------------------------------------------------------------
	// global status and control fields
	// ----------------------------------------------------------------
	localparam int TTP_IRQ_POS = 0;
	localparam int TTP_OVF_POS = 4;
	localparam int TTP_ON_POS  = 8;
	localparam int TTP_OFF_POS = 9;

	// ----------------------------------------------------------------
	// timer config fields
	// ----------------------------------------------------------------
	localparam int TTP_MODE_POS   = 0;
	localparam int TTP_POL_POS    = 2;
	localparam int TTP_REPEAT_POS = 3;
	localparam int TTP_IRQEN_POS  = 4;
	localparam logic [15:0] TTP_CFG_MASK = 16'h001f;

	typedef enum logic [1:0] {
		TTP_MODE_OFF    = 2'h0,
		TTP_MODE_WAVE   = 2'h1,
		TTP_MODE_CAPT   = 2'h2,
		TTP_MODE_EXTEVT = 2'h3
	} ttp_mode_e;

	// ----------------------------------------------------------------
	// timing and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0]  TTP_START_DLY = 2'h3;
	localparam logic [31:0] TTP_CNT_TOP   = 32'hffff_fffe;
	localparam logic [31:0] TTP_ALL_ONES  = 32'hffff_ffff;
	localparam logic [15:0] TTP_REG_RST   = 16'h0000;

	// per timer state
	typedef struct packed {
		logic [15:0] cfg;
		logic [31:0] cnt;
		logic [31:0] prd_sh;
		logic [31:0] wid_sh;
		logic [31:0] prd;
		logic [31:0] wid;
		logic        pend;
		logic        valid;
		logic        en;
		logic        run;
		logic        act;
		logic [1:0]  dly;
		logic [1:0]  errp;
		logic        irq;
		logic        ovf;
		logic        pin;
		logic        pin_oe_n;
	} ttp_tmr_s;

endpackage

// ==== core/ttp_core.sv ====
// triple 32-bit timer with pulse-width output mode, apb register slave
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module ttp_core
	import ttp_pkg::*;
#(
	parameter int NUM_TIMERS = ttp_pkg::TTP_NUM_TMR
) (
	input  wire logic                        core_clk,
	input  wire logic                        rstn,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [ttp_pkg::TTP_AW-1:0]  paddr,
	input  wire logic [ttp_pkg::TTP_DW-1:0]  pwdata,
	output logic      [ttp_pkg::TTP_DW-1:0]  prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [NUM_TIMERS-1:0]       timer_waveform_pin_in,
	output logic      [NUM_TIMERS-1:0]       timer_waveform_pin_out,
	output logic      [NUM_TIMERS-1:0]       timer_waveform_pin_oe_n,
	output logic      [NUM_TIMERS-1:0]       timer_irq
);
	import ttp_pkg::*;

	// ----------------------------------------------------------------
	// parameter check
	// ----------------------------------------------------------------
	// the status word has room for four timers; NUM_TIMERS is held to 1 to TTP_NUM_TMR
	if (NUM_TIMERS < 1 || NUM_TIMERS > TTP_NUM_TMR) begin : g_bad_num
		$error("NUM_TIMERS must be 1 to 3");
	end

	typedef struct packed {
		ttp_tmr_s [NUM_TIMERS-1:0] t;
		logic                      pready;
		logic                      pslverr;
		logic [TTP_DW-1:0]         prdata;
	} ttp_state_s;

	ttp_state_s q;
	ttp_state_s d;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic        acc;
		logic        wr;
		logic        hit;
		logic        gsc_sel;
		logic [2:0]  tidx;
		logic [4:0]  rofs;
		logic [15:0] wd;
		logic [15:0] rd;
		logic        tsel;
		logic        on_w;
		logic        off_w;
		logic        irq_set;
		logic        ovf_set;
		logic        wave;
		logic        ok;
		logic [31:0] nprd;
		logic [31:0] nwid;
		d       = q;
		acc     = psel & penable & q.pready;
		wr      = acc & pwrite;
		wd      = pwdata[15:0];
		gsc_sel = (paddr == TTP_GSC_OFS);
		tidx    = paddr[7:5];
		rofs    = paddr[4:0];
		hit     = gsc_sel;
		rd      = 16'h0000;
		tsel    = 1'b0;
		on_w    = 1'b0;
		off_w   = 1'b0;
		irq_set = 1'b0;
		ovf_set = 1'b0;
		wave    = 1'b0;
		ok      = 1'b0;
		nprd    = '0;
		nwid    = '0;
		d.pready  = psel & ~penable;
		d.pslverr = 1'b0;
		d.prdata  = '0;
		for (int i = 0; i < NUM_TIMERS; i++) begin
			tsel = (paddr[TTP_AW-1:8] == '0) && (tidx == 3'(i + 1)) && (rofs[1:0] == 2'h0)
				&& (rofs <= TTP_WIDL_OFS);
			if (tsel)
				hit = 1'b1;
			// status read image
			if (gsc_sel) begin
				rd[TTP_IRQ_POS + i]   = q.t[i].irq;
				rd[TTP_OVF_POS + i]   = q.t[i].ovf;
				rd[TTP_ON_POS + 2*i]  = q.t[i].en;
				rd[TTP_OFF_POS + 2*i] = q.t[i].en;
			end
			if (tsel) begin
				case (rofs)
					TTP_CFG_OFS:  rd = q.t[i].cfg;
					TTP_CNTH_OFS: rd = q.t[i].cnt[31:16];
					TTP_CNTL_OFS: rd = q.t[i].cnt[15:0];
					TTP_PRDH_OFS: rd = q.t[i].prd_sh[31:16];
					TTP_PRDL_OFS: rd = q.t[i].prd_sh[15:0];
					TTP_WIDH_OFS: rd = q.t[i].wid_sh[31:16];
					default:      rd = q.t[i].wid_sh[15:0];
				endcase
			end

			// per timer sequencing
			wave    = (q.t[i].cfg[TTP_MODE_POS +: 2] == TTP_MODE_WAVE);
			irq_set = 1'b0;
			ovf_set = 1'b0;
			on_w    = wr && gsc_sel && wd[TTP_ON_POS + 2*i];
			off_w   = wr && gsc_sel && wd[TTP_OFF_POS + 2*i];

			// refused values surface two cycles after the width-low write
			d.t[i].errp = {q.t[i].errp[0], 1'b0};
			if (q.t[i].errp[1]) begin
				ovf_set = 1'b1;
				irq_set = 1'b1;
			end

			if (wr && tsel) begin
				case (rofs)
					TTP_CFG_OFS:  d.t[i].cfg = wd & TTP_CFG_MASK;
					TTP_PRDH_OFS: d.t[i].prd_sh[31:16] = wd;
					TTP_PRDL_OFS: d.t[i].prd_sh[15:0] = wd;
					TTP_WIDH_OFS: d.t[i].wid_sh[31:16] = wd;
					TTP_WIDL_OFS: begin
						d.t[i].wid_sh[15:0] = wd;
						nprd = q.t[i].prd_sh;
						nwid = {q.t[i].wid_sh[31:16], wd};
						ok   = (nwid != '0) && (nprd > nwid);
						if (!ok) begin
							d.t[i].errp[0] = 1'b1;
						end else if (q.t[i].run) begin
							d.t[i].pend = 1'b1;
						end else begin
							d.t[i].prd   = nprd;
							d.t[i].wid   = nwid;
							d.t[i].valid = 1'b1;
						end
					end
					default: ;
				endcase
			end

			// start delay and counting
			if (q.t[i].dly != 2'h0) begin
				d.t[i].dly = q.t[i].dly - 2'h1;
				if (q.t[i].dly == 2'h1 && wave && q.t[i].valid) begin
					d.t[i].run = 1'b1;
					d.t[i].act = 1'b1;
					d.t[i].cnt = TTP_ALL_ONES - q.t[i].wid;
				end
			end else if (q.t[i].run) begin
				if (q.t[i].cnt != TTP_CNT_TOP) begin
					d.t[i].cnt = q.t[i].cnt + 32'h1;
				end else begin
					// reload instead of reaching all-ones
					nprd = q.t[i].pend ? q.t[i].prd_sh : q.t[i].prd;
					nwid = q.t[i].pend ? q.t[i].wid_sh : q.t[i].wid;
					if (q.t[i].pend) begin
						d.t[i].prd  = nprd;
						d.t[i].wid  = nwid;
						d.t[i].pend = 1'b0;
					end
					if (q.t[i].act && !q.t[i].cfg[TTP_REPEAT_POS]) begin
						// single pulse ends the run
						d.t[i].run = 1'b0;
						d.t[i].act = 1'b0;
						d.t[i].en  = 1'b0;
						irq_set    = 1'b1;
					end else if (q.t[i].act) begin
						d.t[i].act = 1'b0;
						d.t[i].cnt = TTP_ALL_ONES - (nprd - nwid);
					end else begin
						d.t[i].act = 1'b1;
						d.t[i].cnt = TTP_ALL_ONES - nwid;
						irq_set    = 1'b1;
					end
				end
			end

			// enable / disable, disable wins
			if (off_w) begin
				d.t[i].en  = 1'b0;
				d.t[i].run = 1'b0;
				d.t[i].act = 1'b0;
				d.t[i].dly = 2'h0;
			end else if (on_w && !q.t[i].en) begin
				d.t[i].en  = 1'b1;
				d.t[i].run = 1'b0;
				d.t[i].dly = TTP_START_DLY;
			end

			// sticky flags: a hardware set beats a software clear
			if (wr && gsc_sel && wd[TTP_IRQ_POS + i])
				d.t[i].irq = 1'b0;
			if (wr && gsc_sel && wd[TTP_OVF_POS + i])
				d.t[i].ovf = 1'b0;
			if (irq_set && q.t[i].cfg[TTP_IRQEN_POS])
				d.t[i].irq = 1'b1;
			if (ovf_set)
				d.t[i].ovf = 1'b1;

			// pin follows next state so it leaves a flop in step
			d.t[i].pin_oe_n = ~(d.t[i].cfg[TTP_MODE_POS +: 2] == TTP_MODE_WAVE);
			d.t[i].pin = (d.t[i].cfg[TTP_MODE_POS +: 2] == TTP_MODE_WAVE) && d.t[i].run
				&& (d.t[i].act ~^ d.t[i].cfg[TTP_POL_POS]);
		end
		// counter halves ignore writes
		if (psel && !penable) begin
			d.prdata  = {16'h0000, rd};
			d.pslverr = ~hit;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign prdata  = q.prdata;
	assign pready  = q.pready;
	assign pslverr = q.pslverr;

	for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_out
		assign timer_waveform_pin_out[g]  = q.t[g].pin;
		assign timer_waveform_pin_oe_n[g] = q.t[g].pin_oe_n;
		assign timer_irq[g]               = q.t[g].irq;
	end

endmodule

// ==== bench/ttp_pin_model.sv ====
// far-side model of the three timer pins
`timescale 1ns/1ps
module ttp_pin_model #(
	parameter int N = 3
) (
	input  wire logic         core_clk,
	input  wire logic         rstn,
	input  wire logic [N-1:0] oe_n,
	input  wire logic [N-1:0] drv,
	output logic      [N-1:0] pin
);
	logic [N-1:0] last_q;
	// no pull on the line: a released pin flips every cycle so stale levels never pass
	assign pin = (oe_n & ~last_q) | (~oe_n & drv);
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			last_q <= '0;
		else
			last_q <= pin;
	end
endmodule

// ==== bench/ttp_core_props.sv ====
// port-level assertions for the triple timer core
`timescale 1ns/1ps
module ttp_core_props
	import ttp_pkg::*;
#(
	parameter int NUM_TIMERS = 3
) (
	input wire logic                  core_clk,
	input wire logic                  rstn,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [TTP_AW-1:0]     paddr,
	input wire logic [TTP_DW-1:0]     pwdata,
	input wire logic [TTP_DW-1:0]     prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic [NUM_TIMERS-1:0] timer_waveform_pin_in,
	input wire logic [NUM_TIMERS-1:0] timer_waveform_pin_out,
	input wire logic [NUM_TIMERS-1:0] timer_waveform_pin_oe_n,
	input wire logic [NUM_TIMERS-1:0] timer_irq
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	// ----------------------------------------
	// timer 0 view rebuilt from bus writes
	// ----------------------------------------
	logic [15:0] cfg0_q;
	logic [15:0] wh0_q;
	logic        on0_q;
	logic [1:0]  up_q;
	logic        tk;
	logic        gw;
	logic        m0;
	logic        bad0;
	assign tk = psel && penable && pready && pwrite;
	assign gw = tk && paddr == TTP_GSC_OFS;
	assign m0 = cfg0_q[1:0] == 2'h1;
	assign bad0 = tk && paddr == 12'h038 && wh0_q == 16'h0 && pwdata[15:0] == 16'h0;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			cfg0_q <= 16'h0;
			wh0_q <= 16'h0;
			on0_q <= 1'b0;
			up_q <= 2'h0;
		end else begin
			cfg0_q <= (tk && paddr == 12'h020) ? pwdata[15:0] : cfg0_q;
			wh0_q <= (tk && paddr == 12'h034) ? pwdata[15:0] : wh0_q;
			on0_q <= gw ? (pwdata[8] && !pwdata[9]) || (on0_q && !pwdata[9]) : on0_q;
			up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
		end
	end
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_on_hole: assert property (psel && !penable && paddr[11:8] != 4'h0 |=> pready && pslverr)
		else $error("no error on unmapped access");
	a_irq_needs_en: assert property ($rose(timer_irq[0]) |-> $past(cfg0_q[4]))
		else $error("latch set without irq enable");
	a_irq_clear_write: assert property ($fell(timer_irq[0]) |-> $past(gw && pwdata[0]) || $past(gw && pwdata[0], 2))
		else $error("latch cleared without write");
	a_bad_width_flag: assert property (bad0 && cfg0_q[4] && !timer_irq[0] |=> !timer_irq[0] ##1 !timer_irq[0] ##1 timer_irq[0])
		else $error("refused values not flagged after two cycles");
	a_start_three: assert property (gw && pwdata[8] && !pwdata[9] && !on0_q && m0 && cfg0_q[2]
		|=> !timer_waveform_pin_out[0] [*3] ##1 timer_waveform_pin_out[0])
		else $error("start not three cycles after enable");
	a_pin_low_off: assert property (up_q == 2'h3 && !on0_q && m0 |-> !timer_waveform_pin_out[0])
		else $error("pin not low while disabled");
	a_oe_by_mode: assert property (up_q == 2'h3 |-> timer_waveform_pin_oe_n[0] == !m0)
		else $error("pin drive does not follow mode");
	c_refused: cover property (bad0);
	c_disable: cover property (gw && pwdata[9]);
	c_irq: cover property ($rose(timer_irq[0]));
endmodule
bind ttp_core ttp_core_props #(.NUM_TIMERS(NUM_TIMERS)) u_props (.core_clk, .rstn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .timer_waveform_pin_in, .timer_waveform_pin_out,
	.timer_waveform_pin_oe_n, .timer_irq);

// ==== bench/tb_ttp_core.sv ====
// self-checking bench for the triple timer core
`timescale 1ns/1ps
module tb_ttp_core;
	import ttp_pkg::*;
	logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, err;
	logic [TTP_AW-1:0] paddr;
	logic [TTP_DW-1:0] pwdata, prdata, rd;
	logic [2:0] pin_in, pin_out, oe_n, irq;
	int bad_count, n_checks, hi, per, w, p;
	int badp[3] = '{5, 1, 3};
	int badw[3] = '{0, 2, 3};
	ttp_core #(.NUM_TIMERS(3)) DUT (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .timer_waveform_pin_in(pin_in), .timer_waveform_pin_out(pin_out),
		.timer_waveform_pin_oe_n(oe_n), .timer_irq(irq));
	ttp_pin_model #(.N(3)) u_pin (.core_clk, .rstn, .oe_n, .drv(pin_out), .pin(pin_in));
	function automatic logic [11:0] ta(int t, logic [4:0] o);
		return TTP_TMR_BASE + TTP_TMR_STRIDE * 12'(t) + 12'(o);
	endfunction
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// one transfer; idle cycle first so no signal is driven twice in a step
	task automatic bus(logic wr, logic [11:0] a, logic [31:0] d);
		@(posedge core_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1)
			@(posedge core_clk);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
		// let the write settle before anyone looks at outputs
		#1;
	endtask
	task automatic wt(int t, logic v, output int c);
		c = 0;
		while (pin_out[t] !== v && c < 100) begin
			@(posedge core_clk);
			#1;
			c++;
		end
	endtask
	// asserted cycles and full period, measured at the assertion level
	task automatic meas(int t, logic pol);
		int c;
		#1;
		wt(t, !pol, c);
		wt(t, pol, c);
		wt(t, !pol, hi);
		wt(t, pol, c);
		per = hi + c;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial begin
		#200000;
		bad_count++;
		end_sim();
	end
	initial begin
		{rstn, psel, penable, pwrite, paddr, pwdata} = '0;
		void'($urandom(32'hb065));
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		for (int a = 0; a < 21; a++) begin
			bus(0, ta(a / 7, 5'(4 * (a % 7))), 32'h0);
			chk("reg reset", rd, 32'h0);
		end
		bus(0, TTP_GSC_OFS, 32'h0);
		chk("gsc reset", rd, 32'h0);
		bus(0, 12'h100, 32'h0);
		chk("hole err", {31'h0, err}, 32'h1);
		$display("test reset done");
		bus(1, ta(0, TTP_CFG_OFS), 32'h1d);
		chk("oe", {31'h0, oe_n[0]}, 32'h0);
		for (int i = 0; i < 3; i++) begin
			bus(1, TTP_GSC_OFS, 32'h11);
			bus(1, ta(0, TTP_PRDL_OFS), 32'(badp[i]));
			bus(1, ta(0, TTP_WIDL_OFS), 32'(badw[i]));
			// flags land two cycles after the width-low write
			repeat (2) @(posedge core_clk);
			bus(0, TTP_GSC_OFS, 32'h0);
			chk("refused", rd, 32'h11);
			bus(0, ta(0, TTP_CNTL_OFS), 32'h0);
			chk("cnt kept", rd, 32'h0);
		end
		bus(1, TTP_GSC_OFS, 32'h11);
		bus(0, TTP_GSC_OFS, 32'h0);
		chk("w1c", rd, 32'h0);
		bus(1, ta(0, TTP_CNTH_OFS), $urandom);
		bus(0, ta(0, TTP_CNTH_OFS), 32'h0);
		chk("cnt ro", rd, 32'h0);
		$display("test refuse done");
		bus(1, ta(0, TTP_PRDL_OFS), 32'h2);
		bus(1, ta(0, TTP_WIDL_OFS), 32'h1);
		bus(1, TTP_GSC_OFS, 32'h111);
		meas(0, 1'b1);
		chk("w0", hi, 32'h1);
		chk("p0", per, 32'h2);
		bus(0, TTP_GSC_OFS, 32'h0);
		chk("on bits", rd & 32'h301, 32'h301);
		bus(1, TTP_GSC_OFS, 32'h300);
		bus(0, TTP_GSC_OFS, 32'h0);
		chk("off bits", rd & 32'h300, 32'h0);
		chk("pin off", {31'h0, pin_out[0]}, 32'h0);
		bus(0, ta(0, TTP_CNTH_OFS), 32'h0);
		chk("cnt hold", rd, 32'h0000ffff);
		bus(1, ta(0, TTP_PRDL_OFS), 32'h9);
		bus(1, TTP_GSC_OFS, 32'h100);
		meas(0, 1'b1);
		chk("shadow", per, 32'h2);
		bus(1, ta(0, TTP_WIDL_OFS), 32'h1);
		meas(0, 1'b1);
		meas(0, 1'b1);
		chk("commit", per, 32'h9);
		$display("test timer0 done");
		for (int t = 1; t < 3; t++) begin
			w = 1 + $urandom % 6;
			p = w + 1 + $urandom % 6;
			bus(1, ta(t, TTP_CFG_OFS), (t == 1) ? 32'h9 : 32'hd);
			bus(1, ta(t, TTP_PRDL_OFS), 32'(p));
			bus(1, ta(t, TTP_WIDL_OFS), 32'(w));
			bus(1, TTP_GSC_OFS, 32'h100 << (2 * t));
			meas(t, t == 2);
			chk("width", hi, 32'(w));
			chk("period", per, 32'(p));
			chk("no irq", {31'h0, irq[t]}, 32'h0);
		end
		$display("test random done");
		end_sim();
	end
endmodule
